//--- hdl/timer_pair.v
// two prescaled 8-bit down-counters: pulse measurement and interval timer
// ============================================================
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pair_consts.vh"
module timer_pair #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_b,
  input wire ring_osc_clock,
  input wire measure_input_pin_a,
  input wire measure_input_pin_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg first_timer_irq,
  output reg edge_interrupt_one,
  output reg second_timer_irq,
  output reg second_timer_output_pin,
  output reg first_underflow_out
);
// ============================================================
// reset release and input synchronisers
reg rst_s1;
reg rst_s2;
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    rst_s1 <= 1'b0;
    rst_s2 <= 1'b0;
  end else begin
    rst_s1 <= 1'b1;
    rst_s2 <= rst_s1;
  end
end
wire rst_n = rst_s2;
reg [2:0] pin_s1;
reg [2:0] pin_s2;
reg in_prev;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pin_s1 <= 3'h0;
    pin_s2 <= 3'h0;
  end else begin
    pin_s1 <= {ring_osc_clock, measure_input_pin_b, measure_input_pin_a};
    pin_s2 <= pin_s1;
  end
end
// ============================================================
// registers
reg [7:0] first_timer_mode_reg;
reg [7:0] second_timer_mode_reg;
reg [7:0] pin_control_reg;
reg [WIDTH-1:0] pre1_rl;
reg [WIDTH-1:0] cnt1_rl;
reg [WIDTH-1:0] pre1;
reg [WIDTH-1:0] cnt1;
reg [WIDTH-1:0] pre2_rl;
reg [WIDTH-1:0] cnt2_rl;
reg [WIDTH-1:0] pre2;
reg [WIDTH-1:0] cnt2;
reg [WIDTH-1:0] second_sec;
reg [WIDTH-1:0] pre1_pend;
reg [WIDTH-1:0] cnt1_pend;
reg [WIDTH-1:0] pre2_pend;
reg [WIDTH-1:0] cnt2_pend;
reg [WIDTH-1:0] buffer1;
reg [1:0] stage1;
reg [1:0] stage2;
reg hold1;
reg arm1;
reg arm1_b;
reg ring_prev;
reg [`DIV_BITS-1:0] div;
wire run1 = first_timer_mode_reg[`FM_RUN];
wire pol1 = first_timer_mode_reg[`FM_POLARITY];
wire period1 = first_timer_mode_reg[`FM_PERIOD];
wire run2 = second_timer_mode_reg[`SM_RUN];
wire wc2 = second_timer_mode_reg[`SM_WC];
wire measure_input = pin_control_reg[`PC_PIN_SEL] ? pin_s2[1] : pin_s2[0];
// count source tick from selector and divided clock
function tick_sel;
  input [1:0] sel;
  input [`DIV_BITS-1:0] d;
  input alt;
  begin
    case (sel)
      `SRC_DIV1: tick_sel = 1'b1;
      `SRC_DIV2: tick_sel = d[0];
      `SRC_DIV8: tick_sel = &d;
      default: tick_sel = alt;
    endcase
  end
endfunction
// register address match, shared by every strobe decode
function hit;
  input [3:0] a;
  input [3:0] ofs;
  begin
    hit = a == ofs;
  end
endfunction
wire ring_tick = pin_s2[2] & ~ring_prev;
wire tick1 = tick_sel(first_timer_mode_reg[`FM_SRC_HI:`FM_SRC_LO], div, ring_tick);
wire tick2 = tick_sel(second_timer_mode_reg[`SM_SRC_HI:`SM_SRC_LO], div,
  first_underflow_out);
// level at the chosen polarity; the period ends on the edge leaving it
wire level_ok = measure_input ^ pol1;
wire edge1 = (measure_input != in_prev) && (measure_input == pol1);
wire count_en1 = run1 && stage1 == 2'h0 && (period1 || level_ok);
wire pre1_uf = count_en1 && tick1 && pre1 == `RESET_ZERO;
wire cnt1_uf = pre1_uf && cnt1 == `RESET_ZERO && !arm1_b;
wire count_en2 = run2 && stage2 == 2'h0;
wire pre2_uf = count_en2 && tick2 && pre2 == `RESET_ZERO;
wire cnt2_uf = pre2_uf && cnt2 == `RESET_ZERO;
// bus strobes, answered in the cycle after they are taken
wire acc = (avs_read || avs_write) && avs_waitrequest;
wire do_wr = acc && avs_write;
wire do_rd = acc && avs_read;
wire wr_fp = do_wr && hit(avs_address, `OFS_FIRST_PRESCALER);
wire wr_fc = do_wr && hit(avs_address, `OFS_FIRST_COUNT);
wire wr_sp = do_wr && hit(avs_address, `OFS_SECOND_PRESCALER);
wire wr_sc = do_wr && hit(avs_address, `OFS_SECOND_PRIMARY);
wire [WIDTH-1:0] wdat = avs_writedata[WIDTH-1:0];
// ============================================================
// bus slave: one wait state, unmapped reads give zero
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h0;
  end else begin
    avs_waitrequest <= !(acc);
    avs_readdata <= 32'h0;
    if (do_rd) begin
      if (avs_address == `OFS_FIRST_MODE) begin
        avs_readdata <= {24'h0, first_timer_mode_reg};
      end else if (avs_address == `OFS_FIRST_PRESCALER) begin
        avs_readdata <= {24'h0, pre1};
      end else if (avs_address == `OFS_FIRST_COUNT) begin
        avs_readdata <= {24'h0, period1 ? buffer1 : cnt1};
      end else if (avs_address == `OFS_PIN_CONTROL) begin
        avs_readdata <= {24'h0, pin_control_reg};
      end else if (avs_address == `OFS_SECOND_MODE) begin
        avs_readdata <= {24'h0, second_timer_mode_reg};
      end else if (avs_address == `OFS_SECOND_PRESCALER) begin
        avs_readdata <= {24'h0, pre2};
      end else if (avs_address == `OFS_SECOND_PRIMARY) begin
        avs_readdata <= {24'h0, cnt2};
      end else if (avs_address == `OFS_SECOND_SECONDARY) begin
        avs_readdata <= {24'h0, second_sec};
      end else if (avs_address == `OFS_FLAGS) begin
        avs_readdata <= {29'h0, second_timer_irq, edge_interrupt_one, first_timer_irq};
      end
    end
  end
end
// ============================================================
// control registers and common divider
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    first_timer_mode_reg <= `RESET_ZERO;
    second_timer_mode_reg <= `RESET_ZERO;
    pin_control_reg <= `RESET_ZERO;
    second_sec <= `RESET_BYTE;
    div <= {`DIV_BITS{1'b0}};
    ring_prev <= 1'b0;
    in_prev <= 1'b0;
    second_timer_output_pin <= 1'b0;
  end else begin
    div <= div + 1'b1;
    ring_prev <= pin_s2[2];
    in_prev <= measure_input;
    second_timer_output_pin <= 1'b0; // no port function; the pin is held low in every mode
    if (do_wr && hit(avs_address, `OFS_FIRST_MODE)) begin
      first_timer_mode_reg <= avs_writedata[7:0];
    end
    if (do_wr && hit(avs_address, `OFS_SECOND_MODE)) begin
      second_timer_mode_reg <= avs_writedata[7:0];
    end
    if (do_wr && hit(avs_address, `OFS_PIN_CONTROL)) begin
      pin_control_reg <= avs_writedata[7:0];
    end
    // secondary is stored but unused in timer mode
    if (do_wr && hit(avs_address, `OFS_SECOND_SECONDARY)) begin
      second_sec <= wdat;
    end
  end
end
// ============================================================
// first counter: measurement
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pre1_rl <= `RESET_BYTE;
    cnt1_rl <= `RESET_BYTE;
    pre1 <= `RESET_BYTE;
    cnt1 <= `RESET_BYTE;
    pre1_pend <= `RESET_BYTE;
    cnt1_pend <= `RESET_BYTE;
    stage1 <= 2'h0;
    buffer1 <= `RESET_ZERO;
    hold1 <= 1'b0;
    arm1 <= 1'b0;
    arm1_b <= 1'b0;
    first_underflow_out <= 1'b0;
  end else begin
    first_underflow_out <= cnt1_uf || (arm1_b && pre1_uf);
    if (pre1_uf) begin
      pre1 <= pre1_rl;
    end else if (count_en1 && tick1) begin
      pre1 <= pre1 - 1'b1;
    end
    if (cnt1_uf) begin
      cnt1 <= cnt1_rl;
    end else if (pre1_uf && !arm1_b) begin
      cnt1 <= cnt1 - 1'b1;
    end
    // period mode: capture, then reload, after the active edge
    if (period1 && run1 && edge1) begin
      arm1 <= 1'b1;
    end
    if (arm1 && pre1_uf) begin
      arm1 <= 1'b0;
      arm1_b <= 1'b1;
      if (!hold1) begin
        buffer1 <= cnt1;
        hold1 <= 1'b1;
      end
    end else if (arm1_b && pre1_uf) begin
      arm1_b <= 1'b0;
      cnt1 <= cnt1_rl;
    end
    if (do_rd && hit(avs_address, `OFS_FIRST_COUNT) && period1) begin
      hold1 <= 1'b0;
    end
    // staged write while running, direct load while stopped
    if (!run1 && (wr_fp || wr_fc)) begin
      if (wr_fp) begin
        pre1_rl <= wdat;
        pre1 <= wdat;
      end
      if (wr_fc) begin
        cnt1_rl <= wdat;
        cnt1 <= wdat;
      end
    end else if (wr_fp || wr_fc) begin
      if (wr_fp) begin
        pre1_pend <= wdat;
      end
      if (wr_fc) begin
        cnt1_pend <= wdat;
      end
      stage1 <= 2'h1;
    end else if (stage1 != 2'h0 && tick1) begin
      stage1 <= stage1 == 2'h3 ? 2'h0 : stage1 + 2'h1;
      if (stage1 == 2'h1) begin
        pre1_rl <= pre1_pend;
        cnt1_rl <= cnt1_pend;
      end
      if (stage1 == 2'h2) begin
        pre1 <= pre1_rl;
        cnt1 <= cnt1_rl;
      end
    end
  end
end
// ============================================================
// second counter: interval timer
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pre2_rl <= `RESET_BYTE;
    cnt2_rl <= `RESET_BYTE;
    pre2 <= `RESET_BYTE;
    cnt2 <= `RESET_BYTE;
    pre2_pend <= `RESET_BYTE;
    cnt2_pend <= `RESET_BYTE;
    stage2 <= 2'h0;
  end else begin
    if (pre2_uf) begin
      pre2 <= pre2_rl;
    end else if (count_en2 && tick2) begin
      pre2 <= pre2 - 1'b1;
    end
    if (cnt2_uf) begin
      cnt2 <= cnt2_rl;
    end else if (pre2_uf) begin
      cnt2 <= cnt2 - 1'b1;
    end
    if ((wr_sp || wr_sc) && (!run2 || wc2)) begin
      if (wr_sp) begin
        pre2_rl <= wdat;
      end
      if (wr_sc) begin
        cnt2_rl <= wdat;
      end
      if (wr_sp && !run2) begin
        pre2 <= wdat;
      end
      if (wr_sc && !run2) begin
        cnt2 <= wdat;
      end
    end else if (wr_sp || wr_sc) begin
      if (wr_sp) begin
        pre2_pend <= wdat;
      end
      if (wr_sc) begin
        cnt2_pend <= wdat;
      end
      stage2 <= 2'h1;
    end else if (stage2 != 2'h0 && tick2) begin
      stage2 <= stage2 == 2'h3 ? 2'h0 : stage2 + 2'h1;
      if (stage2 == 2'h1) begin
        pre2_rl <= pre2_pend;
        cnt2_rl <= cnt2_pend;
      end
      if (stage2 == 2'h2) begin
        pre2 <= pre2_rl;
        cnt2 <= cnt2_rl;
      end
    end
  end
end
// ============================================================
// request flags: hardware set wins over a software clear
wire clr = do_wr && hit(avs_address, `OFS_FLAGS);
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    first_timer_irq <= 1'b0;
    edge_interrupt_one <= 1'b0;
    second_timer_irq <= 1'b0;
  end else begin
    if (cnt1_uf || (period1 && arm1_b && pre1_uf)) begin
      first_timer_irq <= 1'b1;
    end else if (clr && avs_writedata[`FL_FIRST]) begin
      first_timer_irq <= 1'b0;
    end
    if (run1 && edge1) begin
      edge_interrupt_one <= 1'b1;
    end else if (clr && avs_writedata[`FL_EDGE]) begin
      edge_interrupt_one <= 1'b0;
    end
    if (cnt2_uf || ((wr_sp || wr_sc) && run2 && !wc2)) begin
      second_timer_irq <= 1'b1;
    end else if (clr && avs_writedata[`FL_SECOND]) begin
      second_timer_irq <= 1'b0;
    end
  end
end
endmodule
`default_nettype wire

//--- hdl/timer_pair_consts.vh
// constants for the prescaled measure and interval timer pair
`ifndef TIMER_PAIR_CONSTS_VH
`define TIMER_PAIR_CONSTS_VH
// ============================================================
// register word offsets (word address)
`define OFS_FIRST_MODE 4'h0
`define OFS_FIRST_PRESCALER 4'h1
`define OFS_FIRST_COUNT 4'h2
`define OFS_PIN_CONTROL 4'h3
`define OFS_SECOND_MODE 4'h4
`define OFS_SECOND_PRESCALER 4'h5
`define OFS_SECOND_PRIMARY 4'h6
`define OFS_SECOND_SECONDARY 4'h7
`define OFS_FLAGS 4'h8
// ============================================================
// first_timer_mode_reg fields
`define FM_RUN 0
`define FM_POLARITY 1
`define FM_PERIOD 2
`define FM_SRC_LO 3
`define FM_SRC_HI 4
// pin_control_reg fields
`define PC_PIN_SEL 0
// second_timer_mode_reg fields
`define SM_RUN 0
`define SM_WC 1
`define SM_SRC_LO 2
`define SM_SRC_HI 3
// flag register fields (write 1 clears)
`define FL_FIRST 0
`define FL_EDGE 1
`define FL_SECOND 2
// ============================================================
// count source selects
`define SRC_DIV1 2'h0
`define SRC_DIV2 2'h1
`define SRC_DIV8 2'h2
`define SRC_ALT 2'h3
`define DIV_BITS 3
`define RESET_BYTE 8'hff
`define RESET_ZERO 8'h00
`endif

//--- testbench/pulse_source.sv
// model of the measured pulse source and ring clock
`timescale 1ns/1ps
`default_nettype none
// ==========
module pulse_source (
  input wire logic clk,
  input wire logic [1:0] level,
  input wire logic ring_en,
  output logic pin_a,
  output logic pin_b,
  output wire logic ring_clk
);
  logic [1:0] div = 2'h0;
  initial pin_a = 1'b0;
  initial pin_b = 1'b0;
  // levels move on whole clocks so no width is shorter than one clock period
  always @(posedge clk) begin
    pin_a <= level[0];
    pin_b <= level[1];
    div <= ring_en ? div + 2'h1 : div;
  end
  // ring clock stands still while disabled
  assign ring_clk = div[1];
endmodule
`default_nettype wire

//--- testbench/timer_pair_bench.sv
// self-checking bench for the timer pair
`timescale 1ns/1ps
`default_nettype none
module timer_pair_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [1:0] level = 2'h0;
  logic ring_en = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, first_timer_irq, edge_interrupt_one, second_timer_irq;
  wire second_timer_output_pin, first_underflow_out, pin_a, pin_b, ring_clk;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t1;
  logic [7:0] rd;
  logic [7:0] rst_val [0:8] = '{8'h0, 8'hff, 8'hff, 8'h0, 8'h0, 8'hff, 8'hff, 8'hff, 8'h0};
  timer_pair u_dut (.clk(clk), .rst_b(rst_b), .ring_osc_clock(ring_clk),
    .measure_input_pin_a(pin_a), .measure_input_pin_b(pin_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_timer_irq(first_timer_irq), .edge_interrupt_one(edge_interrupt_one),
    .second_timer_irq(second_timer_irq), .second_timer_output_pin(second_timer_output_pin),
    .first_underflow_out(first_underflow_out));
  pulse_source u_src (.clk(clk), .level(level), .ring_en(ring_en), .pin_a(pin_a),
    .pin_b(pin_b), .ring_clk(ring_clk));
  // ==========
  initial forever #50 clk = ~clk;
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask
  // waitrequest is sampled as it stood before each edge; no latency is assumed
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) fail("bus hang");
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? first_timer_irq : s == 1 ? edge_interrupt_one :
      s == 2 ? second_timer_irq : first_underflow_out;
  endfunction
  task automatic wait_hi(input int s, input int lim);
    int k;
    k = 0;
    while (sig(s) !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k == lim) fail("no event");
  endtask
  task automatic gap(input int s, input logic [7:0] p);
    bus(1, 4'h8, 8'h7);
    wait_hi(s, 600);
    t1 = cyc;
    bus(1, 4'h8, 8'h7);
    wait_hi(s, 600);
    chk(8'(cyc - t1), p, "period");
  endtask
  task automatic et(input logic [1:0] l, input logic e);
    bus(1, 4'h8, 8'h7);
    level <= l;
    repeat (10) @(posedge clk);
    chk({7'h0, edge_interrupt_one}, {7'h0, e}, "edge");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      bus(0, 4'(i), 8'h0);
      chk(rd, rst_val[i], "reset value");
    end
    bus(1, 4'hc, 8'h5a);
    bus(0, 4'hc, 8'h0);
    chk(rd, 8'h0, "unmapped");
  endtask
  task automatic t_second;
    bus(1, 4'h5, 8'h3);
    bus(1, 4'h6, 8'h4);
    bus(0, 4'h5, 8'h0);
    chk(rd, 8'h3, "live pre");
    bus(0, 4'h6, 8'h0);
    chk(rd, 8'h4, "live pri");
    bus(1, 4'h4, 8'h1);
    gap(2, 8'd20);
    bus(1, 4'h4, 8'h0);
    bus(0, 4'h6, 8'h0);
    t1 = rd;
    repeat (30) @(posedge clk);
    bus(0, 4'h6, 8'h0);
    chk(rd, 8'(t1), "stopped");
    bus(1, 4'h5, 8'hff);
    bus(1, 4'h6, 8'hff);
    bus(1, 4'h4, 8'h1);
    bus(1, 4'h8, 8'h7);
    bus(1, 4'h6, 8'h10);
    wait_hi(2, 3);
    bus(1, 4'h4, 8'h3);
    bus(1, 4'h8, 8'h7);
    bus(1, 4'h6, 8'h10);
    repeat (4) @(posedge clk);
    chk({7'h0, second_timer_irq}, 8'h0, "reload only");
    bus(1, 4'h4, 8'h0);
  endtask
  task automatic t_width;
    int k;
    level <= 2'h1;
    bus(1, 4'h3, 8'h0);
    bus(1, 4'h1, 8'h0);
    bus(1, 4'h2, 8'h7);
    bus(1, 4'h0, 8'h1);
    gap(3, 8'd8);
    bus(1, 4'h5, 8'h0);
    bus(1, 4'h6, 8'h1);
    bus(1, 4'h4, 8'h0d);
    gap(2, 8'd16);
    bus(1, 4'h4, 8'h0);
    level <= 2'h0;
    repeat (4) @(posedge clk);
    k = 0;
    repeat (30) begin
      @(posedge clk);
      k += first_underflow_out;
    end
    chk(8'(k), 8'h0, "counted at low");
    level <= 2'h1;
    bus(1, 4'h0, 8'h19);
    ring_en <= 1'b1;
    wait_hi(3, 200);
    ring_en <= 1'b0;
    bus(1, 4'h0, 8'h0);
  endtask
  task automatic t_edge;
    level <= 2'h0;
    bus(1, 4'h3, 8'h1);
    bus(1, 4'h0, 8'h1);
    et(2'h1, 1'b0);
    et(2'h0, 1'b0);
    et(2'h2, 1'b0);
    et(2'h1, 1'b1);
    bus(1, 4'h0, 8'h3);
    et(2'h3, 1'b1);
    et(2'h1, 1'b0);
    bus(1, 4'h0, 8'h0);
    bus(1, 4'h3, 8'h0);
  endtask
  task automatic t_period;
    level <= 2'h0;
    bus(1, 4'h1, 8'h0);
    bus(1, 4'h2, 8'hff);
    bus(1, 4'h0, 8'h5);
    bus(1, 4'h8, 8'h7);
    level <= 2'h1;
    repeat (20) @(posedge clk);
    level <= 2'h0;
    repeat (20) @(posedge clk);
    level <= 2'h1;
    repeat (10) @(posedge clk);
    chk({6'h0, first_timer_irq, edge_interrupt_one}, 8'h3, "period irq");
    bus(0, 4'h2, 8'h0);
    check_count++;
    // count falls about 29 from the load to the single capture; allow for edge sync slack
    if (rd < 8'hc8 || rd > 8'he8 || $isunknown(rd)) fail("capture");
    bus(1, 4'h0, 8'h0);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail("timeout");
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_second;
    t_width;
    t_edge;
    t_period;
    stop_test;
  end
endmodule
`default_nettype wire

//--- testbench/timer_pair_props.sv
// port checker for the timer pair
`timescale 1ns/1ps
`default_nettype none
// ==========
module timer_pair_props (
  input wire clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire first_timer_irq,
  input wire edge_interrupt_one,
  input wire second_timer_irq,
  input wire second_timer_output_pin,
  input wire first_underflow_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a flag write may clear any flag, so holds are only claimed outside one
  wire clr = avs_write && avs_address == 4'h8;
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence done_s;
    !avs_waitrequest;
  endsequence
  answer_next_a:
    assert property (taken_s |=> done_s) else $error("no answer");
  wait_one_a:
    assert property (done_s |=> avs_waitrequest) else $error("long answer");
  upper_zero_a:
    assert property (done_s |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
  unmapped_a:
    assert property (avs_read && avs_waitrequest && avs_address > 4'h8 |=>
      avs_readdata == 32'h0) else $error("unmapped read");
  out_pin_a:
    assert property (!second_timer_output_pin) else $error("output pin");
  under_irq_a:
    assert property (first_underflow_out |-> ##[0:1] first_timer_irq) else $error("no irq");
  first_hold_a:
    assert property (first_timer_irq && !clr |=> first_timer_irq) else $error("irq lost");
  edge_hold_a:
    assert property (edge_interrupt_one && !clr |=> edge_interrupt_one) else $error("edge lost");
  second_hold_a:
    assert property (second_timer_irq && !clr |=> second_timer_irq) else $error("irq2 lost");
endmodule
bind timer_pair timer_pair_props u_props (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .first_timer_irq(first_timer_irq), .edge_interrupt_one(edge_interrupt_one),
  .second_timer_irq(second_timer_irq), .second_timer_output_pin(second_timer_output_pin),
  .first_underflow_out(first_underflow_out));
`default_nettype wire
